// ---- pkg/rdc_defines.svh ----
`ifndef RDC_DEFINES_SVH
`define RDC_DEFINES_SVH

// Register offsets; the command port sits just above the register space.
`define RDC_OFS_CHIP      6'h00
`define RDC_OFS_PROTO     6'h01
`define RDC_OFS_OPT_FIRST 6'h02
`define RDC_OFS_TMR_HI    6'h04
`define RDC_OFS_TMR_LO    6'h05
`define RDC_OFS_RX_WAIT   6'h08
`define RDC_OFS_CLK_CTRL  6'h09
`define RDC_OFS_OPT_LAST  6'h0b
`define RDC_OFS_IRQ       6'h0c
`define RDC_OFS_COLL      6'h0e
`define RDC_OFS_LEVEL     6'h0f
`define RDC_OFS_FIFO_STAT 6'h1c
`define RDC_OFS_LEN_HI    6'h1d
`define RDC_OFS_LEN_LO    6'h1e
`define RDC_OFS_FIFO      6'h1f
`define RDC_OFS_CMD       6'h20

// Command word layout and command codes.
`define RDC_CMD_FLAG_BIT    7
`define RDC_CMD_IDLE        5'h00
`define RDC_CMD_SOFT_INIT   5'h03
`define RDC_CMD_FIFO_RESET  5'h0f
`define RDC_CMD_TX_NOCRC    5'h10
`define RDC_CMD_TX_CRC      5'h11
`define RDC_CMD_DTX_NOCRC   5'h12
`define RDC_CMD_DTX_CRC     5'h13
`define RDC_CMD_NEXT_SLOT   5'h14
`define RDC_CMD_RX_BLOCK    5'h16
`define RDC_CMD_RX_ENABLE   5'h17
`define RDC_CMD_TEST_INT    5'h18
`define RDC_CMD_TEST_EXT    5'h19

// Reset and protocol preset values.
`define RDC_RST_CHIP      8'h01
`define RDC_RST_PROTO     8'h02
`define RDC_RST_LEVEL     8'h40
`define RDC_PRESET_02     8'h00
`define RDC_PRESET_03     8'h00
`define RDC_PRESET_04     8'hc1
`define RDC_PRESET_05     8'hc1
`define RDC_PRESET_06     8'h00
`define RDC_PRESET_07     8'h0e
`define RDC_PRESET_08     8'h07
`define RDC_PRESET_09     8'h91
`define RDC_PRESET_0A     8'h10
`define RDC_PRESET_0B     8'h87

// Field positions.
`define RDC_CHIP_RX_ON_BIT  1
`define RDC_CHIP_RF_ON_BIT  5
`define RDC_CLK_SEL_LSB     4
`define RDC_LVL_MAIN_LSB    3
`define RDC_LVL_AUX_LSB     0
`define RDC_IRQ_TX_END_BIT  7
`define RDC_IRQ_SOF_BIT     6

// Receive wait time unit and its cycle count at 100 MHz.
`define RDC_CLK_PERIOD_NS   10
`define RDC_RX_WAIT_UNIT_NS 9440
`define RDC_RX_WAIT_UNIT_CYC \
	((`RDC_RX_WAIT_UNIT_NS + `RDC_CLK_PERIOD_NS - 1) / `RDC_CLK_PERIOD_NS)

`endif

// ---- pkg/rdc_pkg.sv ----
package rdc_pkg;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_ARMED,
		TX_TIMER,
		TX_SEND
	} rdc_tx_state_e;

	typedef logic [7:0] rdc_byte_t;

endpackage

// ---- src/rdc_fifo_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

module rdc_fifo_mem #(
	parameter int DEPTH  = 127,
	parameter int ADDR_W = 7
) (
	input  wire logic              clk_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] waddr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic [ADDR_W-1:0] raddr_i,
	output logic      [7:0]        rdata_o
);

	logic [7:0] mem [0:DEPTH-1];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Write-first bypass so a byte pushed into an empty FIFO is seen at once.
	always_ff @(posedge clk_i) begin
		if (we_i && (waddr_i == raddr_i)) begin
			rdata_o <= wdata_i;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule

`default_nettype wire

// ---- src/rdc_direct_cmd.sv ----
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rdc_defines.svh"

// Overview of operation
// - Command word has bit 7 set; code in bits 4..0; else address word.
// - FIFO reset empties the FIFO and clears the FIFO status register.
// - FIFO reset also clears the collision position register.
// - Immediate transmit starts once the first payload byte is in the FIFO.
// - CRC variant flags CRC append; no-CRC variant sends the frame bare.
// - Delayed transmit starts only when the transmit timer expires.
// - Next-slot command sends the protocol slot marker.
// - Block receiver holds bit decoder and framer in reset.
// - Unheld decoder flags start of frame as interrupt, even for noise.
// - Receiver block is released when a transmit operation completes.
// - Nonzero receive wait keeps receiver held that long after transmit.
// - Enable receiver command releases the receiver block.
// - Internal RF test stores both input levels in the level register.
// - Each level is a three-bit code, one step per about 300 mV.
// - External RF test, receiver on and RF off, stores received level.
// - Power-up and enable rising edge restore the vicinity protocol defaults.
// - Writing the protocol register reloads the option register presets.
// - Returning to a protocol restores defaults; host rewrites custom values.
// - Clock output select bits survive protocol selection.
module rdc_direct_cmd
	import rdc_pkg::*;
#(
	parameter int FIFO_DEPTH   = 127,
	parameter int PTR_W        = 7,
	parameter int TX_TIMER_DIV = 1,
	parameter int RX_WAIT_UNIT = `RDC_RX_WAIT_UNIT_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       enable_pin_i,
	input  wire logic [5:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic [2:0] rf_sense_input_a_i,
	input  wire logic [2:0] rf_sense_input_b_i,
	input  wire logic       rx_sof_i,
	input  wire logic       coll_valid_i,
	input  wire logic [7:0] coll_pos_i,
	input  wire logic       tx_ready_i,
	output logic      [7:0] tx_data_o,
	output logic            tx_valid_o,
	output logic            tx_crc_o,
	output logic            tx_start_o,
	output logic            tx_slot_o,
	output logic            tx_end_o,
	output logic            rx_hold_o,
	output logic            irq_o,
	output logic      [1:0] host_clock_output_sel_o
);

	localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(FIFO_DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(FIFO_DEPTH - 1);
	localparam int TMR_DIV_W = $clog2(TX_TIMER_DIV + 1);

	// Pin inputs pass two flip-flops before anything reads them.
	logic [2:0] en_sync;
	logic [2:0] lvl_a_meta;
	logic [2:0] lvl_a_sync;
	logic [2:0] lvl_b_meta;
	logic [2:0] lvl_b_sync;

	rdc_byte_t chip_ctrl;
	rdc_byte_t proto_ctrl;
	rdc_byte_t opt_reg [0:9];
	rdc_byte_t irq_status;
	rdc_byte_t coll_pos;
	rdc_byte_t level_reg;
	rdc_byte_t len_hi;
	rdc_byte_t len_lo;

	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0]   fifo_cnt;
	logic [PTR_W-1:0] mem_raddr;
	rdc_byte_t        fifo_head;

	rdc_tx_state_e    tx_state;
	logic [11:0]      tx_remain;
	logic [13:0]      tx_timer;
	logic [TMR_DIV_W-1:0] tmr_div;
	logic             rx_blocked;
	logic [17:0]      rx_wait;

	logic       en_rise;
	logic       cmd_wr;
	logic [4:0] cmd_code;
	logic       do_preset;
	logic       fifo_clear;
	logic       push;
	logic       host_pop;
	logic       tx_pop;
	logic       pop;
	logic       tx_take;
	logic       tx_done;
	logic       slot_go;
	logic       tx_cmd;
	logic       dtx_cmd;
	logic       opt_wr;
	logic [3:0] opt_idx;
	logic       next_blocked;
	logic [17:0] next_rx_wait;
	rdc_byte_t  next_irq;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			en_sync    <= 3'h0;
			lvl_a_meta <= 3'h0;
			lvl_a_sync <= 3'h0;
			lvl_b_meta <= 3'h0;
			lvl_b_sync <= 3'h0;
		end else begin
			en_sync    <= {en_sync[1:0], enable_pin_i};
			lvl_a_meta <= rf_sense_input_a_i;
			lvl_a_sync <= lvl_a_meta;
			lvl_b_meta <= rf_sense_input_b_i;
			lvl_b_sync <= lvl_b_meta;
		end
	end

	assign en_rise   = en_sync[1] & ~en_sync[2];
	assign cmd_wr    = wr_i && (addr_i == `RDC_OFS_CMD)
		&& wdata_i[`RDC_CMD_FLAG_BIT];
	// Codes with no decode below simply fall through and change nothing.
	assign cmd_code  = wdata_i[4:0];
	// Software init acts like power-up and so shares the preset path.
	assign do_preset = en_rise
		|| (cmd_wr && cmd_code == `RDC_CMD_SOFT_INIT);
	assign fifo_clear = do_preset
		|| (cmd_wr && cmd_code == `RDC_CMD_FIFO_RESET);
	assign tx_cmd  = cmd_wr && tx_state == TX_IDLE
		&& (cmd_code == `RDC_CMD_TX_NOCRC || cmd_code == `RDC_CMD_TX_CRC);
	assign dtx_cmd = cmd_wr && tx_state == TX_IDLE
		&& (cmd_code == `RDC_CMD_DTX_NOCRC || cmd_code == `RDC_CMD_DTX_CRC);
	assign slot_go = cmd_wr && tx_state == TX_IDLE
		&& cmd_code == `RDC_CMD_NEXT_SLOT;
	assign opt_wr  = wr_i && addr_i >= `RDC_OFS_OPT_FIRST
		&& addr_i <= `RDC_OFS_OPT_LAST;
	assign opt_idx = 4'(addr_i - `RDC_OFS_OPT_FIRST);

	// FIFO push and pop; the host may only drain it while no frame is sent.
	assign push     = wr_i && addr_i == `RDC_OFS_FIFO && fifo_cnt < DEPTH_CNT;
	assign host_pop = rd_i && addr_i == `RDC_OFS_FIFO && fifo_cnt != '0
		&& tx_state != TX_SEND;
	assign tx_take  = tx_state == TX_SEND && (!tx_valid_o || tx_ready_i);
	assign tx_pop   = tx_take && tx_remain != 12'h0 && fifo_cnt != '0;
	assign pop      = host_pop || tx_pop;
	assign tx_done  = (tx_take && tx_remain == 12'h0) || slot_go;

	always_comb begin
		if (fifo_clear) begin
			mem_raddr = '0;
		end else if (pop) begin
			mem_raddr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
		end else begin
			mem_raddr = rd_ptr;
		end
	end

	rdc_fifo_mem #(
		.DEPTH  (FIFO_DEPTH),
		.ADDR_W (PTR_W)
	) u_fifo_mem (
		.clk_i   (clk_i),
		.we_i    (push && !fifo_clear),
		.waddr_i (wr_ptr),
		.wdata_i (wdata_i),
		.raddr_i (mem_raddr),
		.rdata_o (fifo_head)
	);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || fifo_clear) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			fifo_cnt <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
			end
			rd_ptr <= mem_raddr;
			fifo_cnt <= fifo_cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

	// Main control and protocol selection.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset) begin
			chip_ctrl  <= `RDC_RST_CHIP;
			proto_ctrl <= `RDC_RST_PROTO;
		end else if (wr_i && addr_i == `RDC_OFS_CHIP) begin
			chip_ctrl <= wdata_i;
		end else if (wr_i && addr_i == `RDC_OFS_PROTO) begin
			proto_ctrl <= wdata_i;
		end
	end

	// Option registers reload on every protocol write; the clock select
	// field is carried over so the host clock never glitches.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset ||
				(wr_i && addr_i == `RDC_OFS_PROTO)) begin
			opt_reg[0] <= `RDC_PRESET_02;
			opt_reg[1] <= `RDC_PRESET_03;
			opt_reg[2] <= `RDC_PRESET_04;
			opt_reg[3] <= `RDC_PRESET_05;
			opt_reg[4] <= `RDC_PRESET_06;
			opt_reg[5] <= `RDC_PRESET_07;
			opt_reg[6] <= `RDC_PRESET_08;
			opt_reg[7] <= `RDC_PRESET_09;
			opt_reg[8] <= `RDC_PRESET_0A;
			opt_reg[9] <= `RDC_PRESET_0B;
			if (rst_b_i && !do_preset) begin
				opt_reg[7][`RDC_CLK_SEL_LSB+:2] <=
					opt_reg[7][`RDC_CLK_SEL_LSB+:2];
			end
		end else if (opt_wr) begin
			opt_reg[opt_idx] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			host_clock_output_sel_o <= 2'h0;
		end else begin
			host_clock_output_sel_o <= opt_reg[7][`RDC_CLK_SEL_LSB+:2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset) begin
			len_hi <= 8'h00;
			len_lo <= 8'h00;
		end else if (wr_i && addr_i == `RDC_OFS_LEN_HI) begin
			len_hi <= wdata_i;
		end else if (wr_i && addr_i == `RDC_OFS_LEN_LO) begin
			len_lo <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		// A position captured in the cycle of a FIFO reset is kept, so a
		// collision reported at that moment is never lost.
		if (!rst_b_i) begin
			coll_pos <= 8'h00;
		end else if (coll_valid_i) begin
			coll_pos <= coll_pos_i;
		end else if (fifo_clear) begin
			coll_pos <= 8'h00;
		end
	end

	// Level register; codes 1..7 stand for 300 mV steps of peak level.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset) begin
			level_reg <= `RDC_RST_LEVEL;
		end else if (cmd_wr && cmd_code == `RDC_CMD_TEST_INT) begin
			level_reg[`RDC_LVL_MAIN_LSB+:3] <= lvl_a_sync;
			level_reg[`RDC_LVL_AUX_LSB+:3]  <= lvl_b_sync;
		end else if (cmd_wr && cmd_code == `RDC_CMD_TEST_EXT
				&& chip_ctrl[`RDC_CHIP_RX_ON_BIT]
				&& !chip_ctrl[`RDC_CHIP_RF_ON_BIT]) begin
			level_reg[`RDC_LVL_MAIN_LSB+:3] <= lvl_a_sync;
		end
	end

	// Transmit sequencer.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset) begin
			tx_state  <= TX_IDLE;
			tx_remain <= 12'h0;
			tx_timer  <= 14'h0;
			tmr_div   <= '0;
			tx_crc_o  <= 1'b0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					tmr_div <= '0;
					if (tx_cmd || dtx_cmd) begin
						tx_crc_o  <= cmd_code[0];
						tx_remain <= {len_hi, len_lo[7:4]};
						tx_timer  <= {opt_reg[2][5:0], opt_reg[3]};
						tx_state  <= tx_cmd ? TX_ARMED : TX_TIMER;
					end
				end
				TX_ARMED: begin
					if (fifo_cnt != '0) begin
						tx_state <= TX_SEND;
					end
				end
				TX_TIMER: begin
					if (tx_timer == 14'h0) begin
						tx_state <= TX_SEND;
					end else if (tmr_div == TMR_DIV_W'(TX_TIMER_DIV - 1)) begin
						tmr_div  <= '0;
						tx_timer <= tx_timer - 14'h1;
					end else begin
						tmr_div <= tmr_div + 1'b1;
					end
				end
				TX_SEND: begin
					if (tx_pop) begin
						tx_remain <= tx_remain - 12'h1;
					end
					if (tx_done) begin
						tx_state <= TX_IDLE;
					end
				end
				default: begin
					tx_state <= TX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset) begin
			tx_valid_o <= 1'b0;
			tx_data_o  <= 8'h00;
		end else if (tx_pop) begin
			tx_valid_o <= 1'b1;
			tx_data_o  <= fifo_head;
		end else if (tx_ready_i) begin
			tx_valid_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			tx_start_o <= 1'b0;
			tx_slot_o  <= 1'b0;
			tx_end_o   <= 1'b0;
		end else begin
			tx_start_o <= !do_preset && (
				(tx_state == TX_ARMED && fifo_cnt != '0) ||
				(tx_state == TX_TIMER && tx_timer == 14'h0));
			tx_slot_o  <= !do_preset && slot_go;
			tx_end_o   <= !do_preset && tx_done;
		end
	end

	// Receiver hold: block command, then release at transmit end or after
	// the programmed wait. Wait is counted in whole cycles of the unit.
	always_comb begin
		next_blocked = rx_blocked;
		next_rx_wait = (rx_wait != 18'h0) ? rx_wait - 18'h1 : 18'h0;
		if (cmd_wr && cmd_code == `RDC_CMD_RX_BLOCK) begin
			next_blocked = 1'b1;
		end else if (cmd_wr && cmd_code == `RDC_CMD_RX_ENABLE) begin
			next_blocked = 1'b0;
			next_rx_wait = 18'h0;
		end else if (tx_done) begin
			next_blocked = 1'b0;
			next_rx_wait = 18'(opt_reg[6] * RX_WAIT_UNIT);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset) begin
			rx_blocked <= 1'b0;
			rx_wait    <= 18'h0;
			rx_hold_o  <= 1'b0;
		end else begin
			rx_blocked <= next_blocked;
			rx_wait    <= next_rx_wait;
			rx_hold_o  <= next_blocked || next_rx_wait != 18'h0;
		end
	end

	// Interrupt status clears on read; a new event in that cycle survives.
	always_comb begin
		next_irq = irq_status;
		if (rd_i && addr_i == `RDC_OFS_IRQ) begin
			next_irq = 8'h00;
		end
		if (rx_sof_i && !rx_hold_o) begin
			next_irq[`RDC_IRQ_SOF_BIT] = 1'b1;
		end
		if (tx_done) begin
			next_irq[`RDC_IRQ_TX_END_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || do_preset) begin
			irq_status <= 8'h00;
			irq_o      <= 1'b0;
		end else begin
			irq_status <= next_irq;
			irq_o      <= next_irq != 8'h00;
		end
	end

	// Read data stand in the cycle after the strobe; unmapped reads are zero.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			if (addr_i >= `RDC_OFS_OPT_FIRST && addr_i <= `RDC_OFS_OPT_LAST) begin
				rdata_o <= opt_reg[opt_idx];
			end else begin
				case (addr_i)
					`RDC_OFS_CHIP:      rdata_o <= chip_ctrl;
					`RDC_OFS_PROTO:     rdata_o <= proto_ctrl;
					`RDC_OFS_IRQ:       rdata_o <= irq_status;
					`RDC_OFS_COLL:      rdata_o <= coll_pos;
					`RDC_OFS_LEVEL:     rdata_o <= level_reg;
					`RDC_OFS_FIFO_STAT: rdata_o <= {1'b0, fifo_cnt[6:0]};
					`RDC_OFS_LEN_HI:    rdata_o <= len_hi;
					`RDC_OFS_LEN_LO:    rdata_o <= len_lo;
					`RDC_OFS_FIFO:      rdata_o <= fifo_head;
					default:            rdata_o <= 8'h00;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ---- tb/rdc_direct_cmd_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module rdc_direct_cmd_props (
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic [5:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rx_sof_i,
	input wire logic       tx_crc_o,
	input wire logic       tx_start_o,
	input wire logic       tx_slot_o,
	input wire logic       tx_end_o,
	input wire logic       rx_hold_o,
	input wire logic       irq_o,
	input wire logic [1:0] host_clock_output_sel_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	logic       cw;
	logic       cmd;
	logic       undef;
	logic       tx_go;
	logic       busy;
	logic       imm;
	logic       crc;
	logic [4:0] code;
	assign cw = wr_i && addr_i == 6'h20;
	assign code = wdata_i[4:0];
	assign cmd = cw && wdata_i[7];
	assign undef = !(code inside {5'h00, 5'h03, 5'h0f, [5'h10:5'h14],
		[5'h16:5'h19]});
	assign tx_go = cmd && code[4:2] == 3'b100 && !busy;

	// Transmit commands are only taken while idle, so track the frame.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || tx_end_o) begin
			busy <= 1'b0;
		end else if (tx_go) begin
			busy <= 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || tx_start_o) begin
			imm <= 1'b0;
		end else if (tx_go) begin
			imm <= !code[1];
		end
	end
	always_ff @(posedge clk_i) begin
		if (tx_go) begin
			crc <= code[0];
		end
	end

	sequence s_load;
		imm && wr_i && addr_i == 6'h1f;
	endsequence
	sequence s_start;
		##[1:3] tx_start_o;
	endsequence

	AST_IMM_START: assert property (s_load |-> s_start)
		else $error("frame did not start after first byte");
	AST_CRC_SEL: assert property (tx_start_o |-> tx_crc_o == crc)
		else $error("crc flag wrong at frame start");
	AST_DLY_HOLD: assert property (tx_go && code[1] |=> !tx_start_o [*8])
		else $error("delayed frame started early");
	AST_SLOT: assert property (
		cmd && code == 5'h14 && !busy |=> tx_slot_o && tx_end_o)
		else $error("slot marker not sent");
	AST_RX_BLOCK: assert property (cmd && code == 5'h16 |=> rx_hold_o)
		else $error("receiver not held");
	AST_RX_ENABLE: assert property (cmd && code == 5'h17 |=> !rx_hold_o)
		else $error("receiver not released");
	AST_SOF_IRQ: assert property (
		rx_sof_i && !rx_hold_o |-> ##[1:2] irq_o)
		else $error("start of frame gave no interrupt");
	AST_TX_RELEASE: assert property (
		tx_end_o && rx_hold_o |-> ##[1:600] !rx_hold_o)
		else $error("receiver still held after transmit");
	AST_CLK_KEEP: assert property (
		wr_i && addr_i == 6'h01 |=> $stable(host_clock_output_sel_o) [*2])
		else $error("clock select changed by protocol write");
	AST_NO_EFFECT: assert property (
		cw && (!wdata_i[7] || undef) |=> $stable(rx_hold_o) && !tx_start_o
		&& !tx_slot_o && !tx_end_o)
		else $error("ignored command word had an effect");
endmodule

`default_nettype wire

// ---- tb/rdc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module rdc_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	output logic      [5:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o
);
	initial begin
		addr_o = 6'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// Each cycle ends one edge late so its effect is settled on return.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask
	task automatic cmd(input logic [4:0] c);
		wr(6'h20, {3'b100, c});
	endtask
endmodule

`default_nettype wire

// ---- tb/rfid_reader_direct_command_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rdc_defines.svh"

module rfid_reader_direct_command_unit_tb_top;
	import rdc_pkg::*;
	localparam int WAIT_UNIT = 2;

	logic       clk_i, rst_b_i, enable_pin_i, wr_i, rd_i, rx_sof_i;
	logic       coll_valid_i, tx_ready_i, tx_valid_o, tx_crc_o, tx_start_o;
	logic       tx_slot_o, tx_end_o, rx_hold_o, irq_o, crc_at;
	logic [5:0] addr_i;
	logic [2:0] rf_a, rf_b;
	logic [1:0] clk_sel;
	rdc_byte_t  wdata_i, rdata_o, coll_pos_i, tx_data_o, d;
	rdc_byte_t  q[$];
	int         error_cnt, checked, cyc, t_cmd, t_start, n, slots;

	rdc_direct_cmd #(.RX_WAIT_UNIT(WAIT_UNIT)) u_rdc_direct_cmd (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .enable_pin_i(enable_pin_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .rf_sense_input_a_i(rf_a),
		.rf_sense_input_b_i(rf_b), .rx_sof_i(rx_sof_i),
		.coll_valid_i(coll_valid_i), .coll_pos_i(coll_pos_i),
		.tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o), .tx_crc_o(tx_crc_o),
		.tx_start_o(tx_start_o), .tx_slot_o(tx_slot_o), .tx_end_o(tx_end_o),
		.rx_hold_o(rx_hold_o), .irq_o(irq_o),
		.host_clock_output_sel_o(clk_sel));
	rdc_host_model u_host (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
		.wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// The sink takes a byte only every other cycle, so the stream must wait.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		tx_ready_i <= ~tx_ready_i;
		if (tx_valid_o && tx_ready_i)
			q.push_back(tx_data_o);
		if (tx_start_o) begin
			t_start <= cyc;
			crc_at <= tx_crc_o;
		end
		if (tx_slot_o)
			slots <= slots + 1;
	end

	task automatic results();
		$display("checks %0d, errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input rdc_byte_t seen, input rdc_byte_t exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input rdc_byte_t e);
		u_host.rd(a, d);
		chk(d, e);
	endtask
	task automatic tick();
		@(posedge clk_i);
		n++;
		if (n > 3000) begin
			error_cnt++;
			results();
		end
	endtask
	task automatic sof();
		rx_sof_i <= 1'b1;
		@(posedge clk_i);
		rx_sof_i <= 1'b0;
	endtask
	task automatic rf(input logic [2:0] a, input logic [4:0] c);
		rf_a <= a;
		repeat (4) @(posedge clk_i);
		u_host.cmd(c);
	endtask

	initial begin
		{rst_b_i, enable_pin_i, rx_sof_i, coll_valid_i, tx_ready_i} = '0;
		{rf_a, rf_b, coll_pos_i} = '0;
		{error_cnt, checked, cyc, t_start, slots} = '0;
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rdc(6'h00, `RDC_RST_CHIP);
		rdc(6'h01, `RDC_RST_PROTO);
		rdc(6'h09, `RDC_PRESET_09);
		rdc(6'h0f, `RDC_RST_LEVEL);
		rdc(6'h15, 8'h00);
		u_host.wr(6'h09, 8'ha5);
		u_host.wr(6'h08, 8'h03);
		u_host.wr(6'h01, 8'h05);
		rdc(6'h08, `RDC_PRESET_08);
		rdc(6'h09, 8'ha1);
		chk(clk_sel, 2'b10);
		u_host.wr(6'h0b, 8'h00);
		u_host.wr(6'h01, `RDC_RST_PROTO);
		rdc(6'h0b, `RDC_PRESET_0B);
		coll_pos_i <= 8'h2a;
		coll_valid_i <= 1'b1;
		@(posedge clk_i);
		coll_valid_i <= 1'b0;
		repeat (3) u_host.wr(6'h1f, 8'h33);
		u_host.wr(6'h20, 8'h0f);
		u_host.cmd(5'h15);
		rdc(6'h1c, 8'h03);
		rdc(6'h0e, 8'h2a);
		u_host.cmd(`RDC_CMD_FIFO_RESET);
		rdc(6'h1c, 8'h00);
		rdc(6'h0e, 8'h00);
		u_host.wr(6'h1d, 8'h00);
		u_host.wr(6'h1e, 8'h20);
		u_host.wr(6'h04, 8'h00);
		u_host.wr(6'h05, 8'h20);
		for (int k = 0; k < 4; k++) begin
			q.delete();
			t_start = 0;
			u_host.cmd(`RDC_CMD_RX_BLOCK);
			chk(rx_hold_o, 1'b1);
			t_cmd = cyc;
			u_host.cmd(5'h10 + 5'(k));
			u_host.wr(6'h1f, 8'ha5);
			u_host.wr(6'h1f, 8'h5a);
			n = 0;
			while (t_start == 0)
				tick();
			chk(crc_at, k[0]);
			chk(t_start - t_cmd > 20, k > 1);
			while (tx_end_o !== 1'b1)
				tick();
			n = 0;
			while (rx_hold_o !== 1'b0)
				tick();
			chk(n >= 7 * WAIT_UNIT - 2 && n <= 7 * WAIT_UNIT + 2, 1);
			chk(8'(q.size()), 8'h02);
			chk(q[0], 8'ha5);
			chk(q[1], 8'h5a);
		end
		rdc(6'h0c, 8'h80);
		sof();
		@(posedge clk_i);
		chk(irq_o, 1'b1);
		rdc(6'h0c, 8'h40);
		u_host.cmd(`RDC_CMD_RX_BLOCK);
		sof();
		rdc(6'h0c, 8'h00);
		u_host.cmd(`RDC_CMD_RX_ENABLE);
		chk(rx_hold_o, 1'b0);
		u_host.cmd(`RDC_CMD_NEXT_SLOT);
		@(posedge clk_i);
		chk(8'(slots), 8'h01);
		rf_b <= 3'd3;
		rf(3'd5, `RDC_CMD_TEST_INT);
		rdc(6'h0f, {2'b01, 3'd5, 3'd3});
		u_host.wr(6'h00, 8'h02);
		rf(3'd6, `RDC_CMD_TEST_EXT);
		rdc(6'h0f, {2'b01, 3'd6, 3'd3});
		u_host.wr(6'h00, 8'h22);
		rf(3'd2, `RDC_CMD_TEST_EXT);
		rdc(6'h0f, {2'b01, 3'd6, 3'd3});
		u_host.wr(6'h08, 8'h01);
		enable_pin_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rdc(6'h08, `RDC_PRESET_08);
		rdc(6'h00, `RDC_RST_CHIP);
		u_host.wr(6'h08, 8'h01);
		u_host.cmd(`RDC_CMD_SOFT_INIT);
		rdc(6'h08, `RDC_PRESET_08);
		results();
	end
endmodule

bind rdc_direct_cmd rdc_direct_cmd_props u_props (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rx_sof_i(rx_sof_i), .tx_crc_o(tx_crc_o),
	.tx_start_o(tx_start_o), .tx_slot_o(tx_slot_o), .tx_end_o(tx_end_o),
	.rx_hold_o(rx_hold_o), .irq_o(irq_o),
	.host_clock_output_sel_o(host_clock_output_sel_o));

`default_nettype wire
